// >>> irq_ctrl_regs.vh
// constants for the interrupt controller: offsets, fields, vectors, timing
// assumes a 40 MHz core clock and an APB slave with 32-bit data
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// register byte offsets
`define ADDR_OPTION      12'h000
`define ADDR_STATUS      12'h004
`define ADDR_FLAGS       12'h008
`define ADDR_PERIPH_EN   12'h00C
`define ADDR_CORE_CTRL   12'h010

// option register fields
`define OPT_LEVEL_BIT    6
`define OPT_EDGE_BIT     5
`define OPT_GEN_BIT      4
`define OPT_RESET        8'h00
`define OPT_WMASK        8'h70

// core control fields (write one to act)
`define CC_RETURN_FROM_IRQ_BIT      0
`define CC_WAIT_BIT      1
`define CC_STOP_BIT      2
`define CC_OPTCLR_BIT    3
`define CC_SPUR_BIT      4

// vector addresses
`define VEC_RESET        12'hFFE
`define VEC_NMI          12'hFFC
`define VEC_EXT1         12'hFF6
`define VEC_EXT2         12'hFF4
`define VEC_TIMER        12'hFF2
`define VEC_ADC          12'hFF0

// timing: one cpu cycle is 13 oscillator cycles
`define OSC_PER_CPU      13
`define RESP_MIN_CPU     6
`define RESP_MAX_CPU     11
`define OPTCLR_CPU       4
`define OPTCLR_WIN_CPU   3'h3

// mode codes in status
`define MODE_NORMAL      2'h0
`define MODE_IRQ         2'h1
`define MODE_NMI         2'h2

`endif

// >>> irq_ctrl.v
// interrupt controller: latches requests, arbitrates, steers the core
// assumes an apb master on i_clk and asynchronous pins on the irq inputs
//
// Contract
// - four maskable sources plus one nonmaskable
// - maskable served only with global enable set
// - accepted request loads its vector into pc
// - shared vector keeps each peripheral flag
// - reset preempts nmi and peripheral routines
// - nmi preempts maskable, never another nmi
// - no maskable nesting, vector one highest
// - any irq wakes wait, few wake stop; the code needs gen set for every wake, nmi included, and stop ignores only adc
// - nmi falling edge latched, cleared at entry
// - peripheral request needs global and own enable
// - external vectors one and two, wake stop
// - vector one edge or level selectable
// - vector two edge, polarity selectable
// - edge latch holds one request, clears entry
// - level mode unstored, sampled at boundary
// - one stuck vector two pin blocks others
// - vector two latch sets on mode changes
// - entry swaps flags, pushes pc, inhibits, vectors
// - return instruction ends routine, resumes main
// - option clear window keeps normal flags
// - response six to eleven cpu cycles
// - cpu cycle is thirteen oscillator cycles
// - option bit six selects vector one level
// - option bit four global enable, reset zero
// - fixed vector addresses per source
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"

module irq_ctrl #(
  parameter NPINS = 4
) (
  // clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // apb slave
  input  wire             i_psel,
  input  wire             i_penable,
  input  wire             i_pwrite,
  input  wire [11:0]      i_paddr,
  input  wire [31:0]      i_pwdata,
  output reg  [31:0]      o_prdata,
  output reg              o_pready,
  output reg              o_pslverr,
  // interrupt sources
  input  wire             i_nmi_n,
  input  wire             i_ext1_n,
  input  wire [NPINS-1:0] i_ext2_pins,
  input  wire [NPINS-1:0] i_ext2_irq_mode,
  input  wire             i_timer_flag,
  input  wire             i_adc_flag,
  // core side
  output reg  [11:0]      o_vector,
  output reg              o_vector_load,
  output reg              o_push_pc,
  output reg              o_irq_flags_sel,
  output reg              o_nmi_flags_sel,
  output reg              o_core_ready,
  output reg              o_wake
);

  localparam ST_RUN   = 4'b0001;
  localparam ST_RESP  = 4'b0010;
  localparam ST_SLEEP = 4'b0100;
  localparam ST_IDLE  = 4'b1000;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers, every pin passes two flops
  reg [NPINS+3:0] sync1_q;
  reg [NPINS+3:0] sync2_q;
  wire [NPINS+3:0] raw = {i_ext2_pins, i_adc_flag, i_timer_flag,
                          i_ext1_n, i_nmi_n};

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= {{NPINS{1'b1}}, 4'h3};  // idle: pins high, flags low
      sync2_q <= {{NPINS{1'b1}}, 4'h3};
    end
    else
    begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  wire            nmi_s   = sync2_q[0];
  wire            ext1_s  = sync2_q[1];
  wire            tmr_s   = sync2_q[2];
  wire            adc_s   = sync2_q[3];
  wire [NPINS-1:0] pins_s = sync2_q[NPINS+3:4];

  ////////////////////////////////////////////////////////////////////////
  // registers and cpu cycle divider
  reg [7:0]  opt_q;
  reg [1:0]  pen_q;
  reg [3:0]  div_q;
  reg [3:0]  state_q;
  reg [3:0]  resp_q;
  reg [1:0]  mode_q;
  reg [2:0]  optclr_q;
  reg        nmi_prev_q;
  reg        ext1_prev_q;
  reg        ext2_prev_q;
  reg        nmi_lat_q;
  reg        ext1_lat_q;
  reg        ext2_lat_q;
  reg        stop_q;
  reg [2:0]  cur_q;
  reg [1:0]  back_mode_q;
  reg        back_isel_q;

  wire gen     = opt_q[`OPT_GEN_BIT];
  wire lvl1    = opt_q[`OPT_LEVEL_BIT];
  wire rise2   = opt_q[`OPT_EDGE_BIT];
  wire cpu_tick = (div_q == (`OSC_PER_CPU - 1));

  wire wr = i_psel & i_penable & i_pwrite;
  wire rd_ok = (i_paddr == `ADDR_OPTION) | (i_paddr == `ADDR_STATUS) |
               (i_paddr == `ADDR_FLAGS) | (i_paddr == `ADDR_PERIPH_EN) |
               (i_paddr == `ADDR_CORE_CTRL);
  wire wr_opt = wr & (i_paddr == `ADDR_OPTION);
  wire wr_cc  = wr & (i_paddr == `ADDR_CORE_CTRL);
  wire wr_pen = wr & (i_paddr == `ADDR_PERIPH_EN);
  wire do_return_from_irq = wr_cc & i_pwdata[`CC_RETURN_FROM_IRQ_BIT];
  wire do_wait = wr_cc & i_pwdata[`CC_WAIT_BIT];
  wire do_stop = wr_cc & i_pwdata[`CC_STOP_BIT];
  wire do_oclr = wr_cc & i_pwdata[`CC_OPTCLR_BIT];
  wire do_spur = wr_cc & i_pwdata[`CC_SPUR_BIT];

  // cpu cycle divider, one tick every thirteen clocks
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      div_q <= 4'h0;
    else if (cpu_tick)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // edge detection on nmi and vector lines
  // vector two pins are anded (falling) or ored (rising): one stuck pin
  // masks the others, a known limitation kept for compatibility
  wire [NPINS-1:0] act2 = pins_s | ~i_ext2_irq_mode;
  wire ext2_comb = rise2 ? |(pins_s & i_ext2_irq_mode) : &act2;
  wire nmi_fall  = nmi_prev_q & ~nmi_s;
  wire ext1_fall = ext1_prev_q & ~ext1_s & ~lvl1;
  wire ext2_edge = rise2 ? (~ext2_prev_q & ext2_comb)
                         : (ext2_prev_q & ~ext2_comb);
  // selecting rising mode with a pulled-up pin fakes an edge
  wire spur2 = (wr_opt & i_pwdata[`OPT_EDGE_BIT] & ~rise2 &
                |(pins_s & i_ext2_irq_mode)) | do_spur;

  // request candidates
  wire ext1_req = lvl1 ? ~ext1_s : ext1_lat_q;
  wire tmr_req  = tmr_s & pen_q[0];
  wire adc_req  = adc_s & pen_q[1];
  wire any_mask = ext1_req | ext2_lat_q | tmr_req | adc_req;
  wire boundary = cpu_tick & (state_q == ST_RUN);
  wire take_nmi = nmi_lat_q & (mode_q != `MODE_NMI);
  wire take_msk = gen & any_mask & (mode_q == `MODE_NORMAL);
  wire accept   = boundary & ~wr_cc & (take_nmi | take_msk); // keeps latch

  // fixed priority: nmi, then vector one down to four
  reg [2:0]  sel;
  reg [11:0] vec;
  always @*
  begin
    sel = 3'h0;
    vec = `VEC_NMI;
    if (take_nmi)
      sel = 3'h0;
    else if (ext1_req)
    begin
      sel = 3'h1;
      vec = `VEC_EXT1;
    end
    else if (ext2_lat_q)
    begin
      sel = 3'h2;
      vec = `VEC_EXT2;
    end
    else if (tmr_req)
    begin
      sel = 3'h3;
      vec = `VEC_TIMER;
    end
    else
    begin
      sel = 3'h4;
      vec = `VEC_ADC;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request latches: set wins over entry clear
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      nmi_prev_q  <= 1'b1;
      ext1_prev_q <= 1'b1;
      ext2_prev_q <= 1'b1;
      nmi_lat_q   <= 1'b0;
      ext1_lat_q  <= 1'b0;
      ext2_lat_q  <= 1'b0;
    end
    else
    begin
      nmi_prev_q  <= nmi_s;
      ext1_prev_q <= ext1_s;
      ext2_prev_q <= ext2_comb;
      if (nmi_fall)
        nmi_lat_q <= 1'b1;
      else if (accept && sel == 3'h0)
        nmi_lat_q <= 1'b0;
      if (ext1_fall)
        ext1_lat_q <= 1'b1;
      else if ((accept && sel == 3'h1) || lvl1)
        ext1_lat_q <= 1'b0;
      if (ext2_edge || spur2)
        ext2_lat_q <= 1'b1;
      else if (accept && sel == 3'h2)
        ext2_lat_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // option register, peripheral enables, option clear window
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      opt_q    <= `OPT_RESET;
      pen_q    <= 2'h0;
      optclr_q <= 3'h0;
    end
    else
    begin
      if (wr_opt)
        opt_q <= i_pwdata[7:0] & `OPT_WMASK;
      else if (cpu_tick && optclr_q == 3'h1)
        opt_q <= `OPT_RESET;  // clear lands after the window
      if (wr_pen)
        pen_q <= i_pwdata[1:0];
      // counts down the first three cpu cycles of the option clear
      if (do_oclr)
        optclr_q <= `OPTCLR_WIN_CPU;
      else if (cpu_tick && optclr_q != 3'h0)
        optclr_q <= optclr_q - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // service sequencer: entry, response wait, sleep, return
  // mode starts nmi so the init routine cannot be interrupted
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q         <= ST_IDLE;
      mode_q          <= `MODE_NMI;
      resp_q          <= 4'h0;
      stop_q          <= 1'b0;
      cur_q           <= 3'h0;
      back_mode_q     <= `MODE_NORMAL;
      back_isel_q     <= 1'b0;
      o_vector        <= `VEC_RESET;
      o_vector_load   <= 1'b0;
      o_push_pc       <= 1'b0;
      o_irq_flags_sel <= 1'b0;
      o_nmi_flags_sel <= 1'b1;
      o_core_ready    <= 1'b0;
      o_wake          <= 1'b0;
    end
    else
    begin
      o_vector_load <= 1'b0;
      o_push_pc     <= 1'b0;
      o_wake        <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // first cycle after reset loads the reset vector
          o_vector_load <= 1'b1;
          o_core_ready  <= 1'b1;
          state_q       <= ST_RUN;
        end
        ST_RUN:
        begin
          if (do_return_from_irq)
          begin
            // an nmi return resumes the routine it preempted
            mode_q          <= back_mode_q;
            o_irq_flags_sel <= back_isel_q;
            o_nmi_flags_sel <= 1'b0;
            back_mode_q     <= `MODE_NORMAL;
            back_isel_q     <= 1'b0;
          end
          else if (do_wait || do_stop)
          begin
            stop_q  <= do_stop;
            state_q <= ST_SLEEP;
          end
          else if (accept)
          begin
            cur_q         <= sel;
            o_vector      <= vec;
            o_vector_load <= 1'b1;
            o_push_pc     <= 1'b1;
            o_core_ready  <= 1'b0;
            resp_q        <= 4'h0;
            state_q       <= ST_RESP;
            if (sel == 3'h0)
            begin
              mode_q          <= `MODE_NMI;
              back_mode_q     <= mode_q;
              back_isel_q     <= o_irq_flags_sel;
              o_nmi_flags_sel <= 1'b1;
              o_irq_flags_sel <= 1'b0;
            end
            else
            begin
              mode_q          <= `MODE_IRQ;
              // inside the clear window flags stay normal
              o_irq_flags_sel <= (optclr_q == 3'h0);
            end
          end
        end
        ST_RESP:
        begin
          // waits exactly six cpu cycles; entry lands on a tick, so no phase slack
          if (cpu_tick)
          begin
            resp_q <= resp_q + 4'h1;
            if (resp_q == (`RESP_MIN_CPU - 1))
            begin
              o_core_ready <= 1'b1;
              state_q      <= ST_RUN;
            end
          end
        end
        ST_SLEEP:
        begin
          // nmi wakes only with gen set; stop ignores the adc source
          if ((gen && (nmi_lat_q || ext1_req || ext2_lat_q || tmr_req ||
               (adc_req && !stop_q))))
          begin
            o_wake  <= 1'b1;
            state_q <= ST_RUN;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, unmapped address errors
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~rd_ok;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite)
      begin
        case (i_paddr)
          `ADDR_STATUS:
            o_prdata <= {20'h0_0000, state_q, 1'b0, cur_q, mode_q, 2'h0};
          `ADDR_FLAGS:
            o_prdata <= {26'h0, adc_s, tmr_s, ext2_lat_q, ext1_req,
                         nmi_lat_q, 1'b0};
          `ADDR_PERIPH_EN:
            o_prdata <= {30'h0, pen_q};
          default: o_prdata <= 32'h0000_0000; // option reg write only
        endcase
      end
    end
  end

endmodule // irq_ctrl

// >>> irq_ctrl_assertions.sv
// port checker for the interrupt controller
// assumes the regs header; bound to every irq_ctrl below
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module irq_ctrl_assertions (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pready,
  input wire [11:0] o_vector,
  input wire        o_vector_load,
  input wire        o_push_pc,
  input wire        o_irq_flags_sel,
  input wire        o_nmi_flags_sel,
  input wire        o_core_ready
);
  reg       gen_q;
  reg       busy_q;
  reg [7:0] wait_q;
  ////////////////////////////////////////
  // enable mirror; cycles since the last entry
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      gen_q  <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 8'h00;
    end
    else
    begin
      if (i_psel && i_penable && i_pwrite && o_pready &&
          i_paddr == `ADDR_OPTION)
        gen_q <= i_pwdata[`OPT_GEN_BIT];
      busy_q <= o_push_pc | (busy_q & ~o_core_ready);
      wait_q <= o_push_pc ? 8'h00 : wait_q + 8'h01;
    end
  ////////////////////////////////////////
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  push_load_a:
    assert property (o_push_pc |-> o_vector_load)
    else $error("pc push without vector load");
  load_pulse_a:
    assert property (o_vector_load |=> !o_vector_load)
    else $error("vector load longer than one cycle");
  vector_set_a:
    assert property (o_vector_load |-> o_vector inside {`VEC_RESET,
      `VEC_NMI, `VEC_EXT1, `VEC_EXT2, `VEC_TIMER, `VEC_ADC})
    else $error("vector outside the table");
  entry_halt_a:
    assert property (o_push_pc |=> !o_core_ready [*8])
    else $error("core not held after entry");
  resp_time_a:
    assert property ($rose(o_core_ready) && busy_q |->
      wait_q >= 8'd74 && wait_q <= 8'd80)
    else $error("response time off");
  gen_gate_a:
    assert property (o_push_pc && o_vector != `VEC_NMI |-> $past(gen_q))
    else $error("maskable entry with enable clear");
  nmi_nest_a:
    assert property (o_push_pc |-> !$past(o_nmi_flags_sel))
    else $error("entry inside nmi routine");
  irq_nest_a:
    assert property (o_push_pc && $past(o_irq_flags_sel) |->
      o_vector == `VEC_NMI)
    else $error("maskable routine nested");
  nmi_flags_a:
    assert property ($rose(o_nmi_flags_sel) |-> o_vector == `VEC_NMI)
    else $error("nmi flags without nmi vector");
  apb_ready_a:
    assert property (i_psel && !i_penable |=> o_pready)
    else $error("apb access not answered");
endmodule // irq_ctrl_assertions

bind irq_ctrl irq_ctrl_assertions chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_vector(o_vector),
  .o_vector_load(o_vector_load), .o_push_pc(o_push_pc),
  .o_irq_flags_sel(o_irq_flags_sel), .o_nmi_flags_sel(o_nmi_flags_sel),
  .o_core_ready(o_core_ready));

// >>> core_model.sv
// core stand-in: follows vector loads, keeps return stack depth
// assumes the bench pulses i_return_from_irq as each routine ends
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // controller side
  input  wire [11:0] i_vector,
  input  wire        i_vector_load,
  input  wire        i_push_pc,
  input  wire        i_return_from_irq,
  // bench side
  output reg  [11:0] o_pc,
  output reg  [7:0]  o_entries,
  output reg  [2:0]  o_depth
);
  ////////////////////////////////////////
  // reset drops any routine, so the stack empties
  always @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_pc      <= 12'h000;
      o_entries <= 8'h00;
      o_depth   <= 3'h0;
    end
    else
    begin
      if (i_vector_load)
      begin
        o_pc      <= i_vector;
        o_entries <= o_entries + 8'h01;
      end
      if (i_push_pc)
        o_depth <= o_depth + 3'h1;
      else if (i_return_from_irq && o_depth != 3'h0) // reset routine has no frame
        o_depth <= o_depth - 3'h1;
    end
endmodule // core_model

// >>> tb_mcu_interrupt_controller.sv
// self-checking bench for the interrupt controller
// assumes the bound checker and the core model beside it
`timescale 1ns/1ps
`include "irq_ctrl_regs.vh"
module tb_mcu_interrupt_controller;
  reg         i_clk, i_rst_n, psel, pen, pwr;
  reg         nmi_n, ext1_n, tmr, adc, return_from_irq, errq;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, seed, rd;
  reg  [3:0]  pins;
  reg  [7:0]  n0, wakes;
  wire [31:0] prdata;
  wire [11:0] vec, pc;
  wire [7:0]  entries;
  wire [2:0]  depth;
  wire        pready, pslverr, vload, push, isel, nsel, rdy, wake;
  integer     err_count, n_checks, s;

  irq_ctrl #(.NPINS(4)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_nmi_n(nmi_n),
    .i_ext1_n(ext1_n), .i_ext2_pins(pins), .i_ext2_irq_mode(4'hF),
    .i_timer_flag(tmr), .i_adc_flag(adc), .o_vector(vec),
    .o_vector_load(vload), .o_push_pc(push), .o_irq_flags_sel(isel),
    .o_nmi_flags_sel(nsel), .o_core_ready(rdy), .o_wake(wake));
  core_model core (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_vector(vec), .i_vector_load(vload),
    .i_push_pc(push), .i_return_from_irq(return_from_irq), .o_pc(pc), .o_entries(entries),
    .o_depth(depth));

  ////////////////////////////////////////
  // 40 MHz clock; wake pulses counted as they come
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (wake === 1'b1)
      wakes <= wakes + 8'h01;

  task check(input [95:0] what, input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("Error %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // xorshift keeps the pin choice repeatable
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  // fixed priority order, highest first
  function [11:0] vec_of(input [2:0] k);
    case (k)
      3'h1: vec_of = `VEC_EXT1;
      3'h2: vec_of = `VEC_EXT2;
      3'h3: vec_of = `VEC_TIMER;
      default: vec_of = `VEC_ADC;
    endcase
  endfunction

  // apb transfer held until pready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      k = 0;
      @(posedge i_clk);
      while (pready !== 1'b1 && k < 20)
      begin
        @(posedge i_clk);
        k = k + 1;
      end
      rd = prdata;
      errq = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge i_clk);
      if (k == 20)
      begin
        err_count = err_count + 1;
        stop_test;
      end
    end
  endtask

  // return instruction once the core runs again
  task ret;
    integer k;
    begin
      for (k = 0; k < 200 && rdy !== 1'b1; k = k + 1)
        @(posedge i_clk);
      if (k == 200)
        err_count = err_count + 1;
      return_from_irq <= 1'b1;
      @(posedge i_clk);
      return_from_irq <= 1'b0;
      apb(1, `ADDR_CORE_CTRL, 32'h1 << `CC_RETURN_FROM_IRQ_BIT);
    end
  endtask

  task expect_entry(input [11:0] v);
    integer k;
    begin
      k = 0;
      while (entries === n0 && k < 400)
      begin
        @(posedge i_clk);
        k = k + 1;
      end
      check("vector", pc, v);
      n0 = entries;
      if (k == 400)
      begin
        err_count = err_count + 1;
        stop_test;
      end
    end
  endtask

  task quiet(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      check("no entry", entries, n0);
    end
  endtask

  // short low pulse: nmi pin or vector one line
  task blip(input b);
    begin
      if (b)
        ext1_n <= 1'b0;
      else
        nmi_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      ext1_n <= 1'b1;
      nmi_n <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
  endtask

  ////////////////////////////////////////
  // main sequence
  initial
  begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    {psel, pen, pwr, tmr, adc, return_from_irq} = 6'h00;
    {nmi_n, ext1_n} = 2'h3;
    pins = 4'hF;
    paddr = 12'h000;
    pwdata = 32'h0;
    wakes = 8'h00;
    err_count = 0;
    n_checks = 0;
    seed = 32'h10;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    check("reset pc", pc, `VEC_RESET);
    check("nmi mode", nsel, 1);
    n0 = entries;
    apb(0, `ADDR_OPTION, 0);
    check("option read", rd, 0);
    apb(0, 12'h0F0, 0);
    check("unmapped", errq, 1);
    ret;
    blip(1);
    quiet(150);
    apb(0, `ADDR_FLAGS, 0);
    check("v1 flag", rd[2], 1);
    apb(1, `ADDR_OPTION, 32'h10);
    expect_entry(`VEC_EXT1);
    check("irq flags", isel, 1);
    ret;
    $display("test enable done");
    // every maskable source pending at once, enable off
    apb(1, `ADDR_OPTION, 0);
    apb(1, `ADDR_PERIPH_EN, 3);
    blip(1);
    blip(1);
    seed = xs(seed);
    pins[seed[1:0]] <= 1'b0;
    tmr <= 1'b1;
    adc <= 1'b1;
    repeat (3) @(posedge i_clk);
    pins <= 4'hF;
    apb(1, `ADDR_OPTION, 32'h10);
    for (s = 1; s < 5; s = s + 1)
    begin
      expect_entry(vec_of(s[2:0]));
      if (s == 3)
        tmr <= 1'b0;
      if (s == 4)
        adc <= 1'b0;
      ret;
    end
    quiet(150);
    check("stack", depth, 0);
    $display("test priority done");
    apb(1, `ADDR_OPTION, 32'h30);
    expect_entry(`VEC_EXT2);
    ret;
    pins <= 4'h0;
    quiet(60);
    pins[1] <= 1'b1;
    expect_entry(`VEC_EXT2);
    pins <= 4'hF;
    ret;
    apb(1, `ADDR_OPTION, 32'h10);
    pins[0] <= 1'b0;
    expect_entry(`VEC_EXT2);
    ret;
    pins[2] <= 1'b0;
    quiet(100);
    pins <= 4'hF;
    apb(1, `ADDR_CORE_CTRL, 32'h1 << `CC_SPUR_BIT);
    expect_entry(`VEC_EXT2);
    ret;
    $display("test vector two done");
    apb(1, `ADDR_OPTION, 32'h50);
    ext1_n <= 1'b0;
    expect_entry(`VEC_EXT1);
    ext1_n <= 1'b1;
    ret;
    quiet(100);
    $display("test level done");
    apb(1, `ADDR_OPTION, 32'h10);
    blip(1);
    expect_entry(`VEC_EXT1);
    blip(0);
    expect_entry(`VEC_NMI);
    check("nmi flags", nsel, 1);
    blip(0);
    quiet(60);
    ret;
    expect_entry(`VEC_NMI);
    ret;
    ret;
    check("stack", depth, 0);
    $display("test nmi done");
    // request inside the option clear window keeps normal flags
    apb(1, `ADDR_CORE_CTRL, 32'h1 << `CC_OPTCLR_BIT);
    blip(1);
    expect_entry(`VEC_EXT1);
    check("clr flags", isel, 0);
    ret;
    blip(1);
    quiet(100);
    apb(1, `ADDR_OPTION, 32'h10);
    expect_entry(`VEC_EXT1);
    ret;
    $display("test option clear done");
    apb(1, `ADDR_CORE_CTRL, 32'h1 << `CC_WAIT_BIT);
    adc <= 1'b1;
    expect_entry(`VEC_ADC);
    check("wakes", wakes, 1);
    adc <= 1'b0;
    ret;
    apb(1, `ADDR_CORE_CTRL, 32'h1 << `CC_STOP_BIT);
    adc <= 1'b1;
    quiet(100);
    adc <= 1'b0;
    blip(1);
    expect_entry(`VEC_EXT1);
    check("wakes", wakes, 2);
    ret;
    $display("test sleep done");
    blip(1);
    expect_entry(`VEC_EXT1);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    check("reset pc", pc, `VEC_RESET);
    check("nmi mode", nsel, 1);
    $display("test late reset done");
    stop_test;
  end
endmodule // tb_mcu_interrupt_controller
